/* logic/readback_consts.vh */
// Constants for the conversion data readback block
`ifndef READBACK_CONSTS_VH
`define READBACK_CONSTS_VH

// ----------------------------------------------------------------
// Read opcodes
// ----------------------------------------------------------------
`define OP_READ_MAIN_A    8'h12
`define OP_READ_MAIN_B    8'h13
`define OP_READ_AUX_A     8'h14
`define OP_READ_AUX_B     8'h15

// ----------------------------------------------------------------
// Data field layout
// ----------------------------------------------------------------
`define PAD_BYTE          8'h00
`define WORD_BYTES        3'h4
`define LAST_BIT          3'h7
`define MAIN_W            32
`define AUX_W             24
`define BYTE_W            8
`define ALARM_W           4

// ----------------------------------------------------------------
// Status byte fields
// ----------------------------------------------------------------
`define ST_AUX_NEW        7
`define ST_MAIN_NEW       6
`define ST_CLK_SRC        5
`define ST_ALARM_HI       4
`define ST_ALARM_LO       1
`define ST_RESET          0

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define RST_BYTE          8'h00
`define RST_WORD          32'h00000000
`define RST_AUX           24'h000000
`define RST_CNT3          3'h0

`endif

/* logic/pin_sync.v */
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module pin_sync #(
	parameter RESET_VAL = 1'b0
) (
	// Clock and reset
	input  wire core_clk,
	input  wire resetn,
	input  wire clkEn,
	// Pin and filtered level
	input  wire pinIn,
	output reg  level
);

	reg stage1;
	reg stage2;
	reg stage3;

	// Level moves only once the second and third stages agree
	always @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			stage1 <= RESET_VAL;
			stage2 <= RESET_VAL;
			stage3 <= RESET_VAL;
			level  <= RESET_VAL;
		end else if (clkEn) begin
			stage1 <= pinIn;
			stage2 <= stage1;
			stage3 <= stage2;
			if (stage2 == stage3) begin
				level <= stage3;
			end
		end
	end

endmodule

/* logic/conversion_data_readback.v */
// Serial readback path for main and auxiliary conversion results
`timescale 1ns/1ps
`include "readback_consts.vh"

// Behaviour
// - Direct readback shifts main result out with no opcode needed.
// - Input bytes are decoded during direct readback; host holds input low otherwise.
// - A command received during direct readback executes; stream may break.
// - New result during any transaction goes only to holding register.
// - Conversion restart clears the main holding register.
// - Main field is optional status, four result bytes, optional checksum.
// - Clocking beyond the last byte resends the sequence from the start; command reads stop after the last byte instead.
// - Continuous mode: ready rises on first clock fall; pulse: on start.
// - With select low, shared pin falls together with ready output.
// - Command read returns addressed converter's holding register any time.
// - New-data bit is 1 if new since last read, else 0.
// - Auxiliary results are only readable by command.
// - MSB appears on first serial clock rise after the read opcode.
// - Aux field: optional status, three result bytes, zero pad, optional checksum.
// - Further commands are ignored until read ends or select goes high.
// - Main read opcodes are 12h/13h, auxiliary read opcodes 14h/15h.
// - Without status byte all later bytes move up one position.
// - Status byte inclusion follows the status-enable bit.
// - Status bits: aux new, main new, clock, ref, amp low/high/diff, reset.
// - Clock-source bit reads 0 on internal oscillator.
// - Clock-source bit reads 1 on external clock.
// - Amplifier and reference alarms only meaningful in main readback.
// - Reset flag sets on any reset, holds until host clears it.
module conversion_data_readback (
	// Clock, reset, enable
	input  wire                   core_clk,
	input  wire                   resetn,
	input  wire                   clkEn,
	// Serial pins
	input  wire                   sclk,
	input  wire                   chipSelectN,
	input  wire                   serialIn,
	output reg                    serial_out_ready_pin,
	output reg                    serialOutEn,
	// Converter results
	input  wire                   mainReady,
	input  wire [`MAIN_W-1:0]     mainResult,
	input  wire [`BYTE_W-1:0]     mainChecksum,
	input  wire                   auxReady,
	input  wire [`AUX_W-1:0]      auxResult,
	input  wire [`BYTE_W-1:0]     auxChecksum,
	// Configuration and status
	input  wire                   statusEnable,
	input  wire                   checksumEnable,
	input  wire                   pulseMode,
	input  wire                   convStart,
	input  wire                   convRestart,
	input  wire                   regAccessBusy,
	input  wire                   clock_source_flag,
	input  wire                   low_reference_alarm,
	input  wire                   amp_low_alarm,
	input  wire                   amp_high_alarm,
	input  wire                   amp_differential_alarm,
	input  wire                   resetFlagClear,
	// Ready and command outputs
	output reg                    conversion_ready_n,
	output reg                    cmdStrobe,
	output reg  [`BYTE_W-1:0]     cmdByte,
	output reg                    resetFlag
);

	// ----------------------------------------------------------------
	// States
	// ----------------------------------------------------------------
	localparam [2:0] ST_IDLE   = 3'h1;
	localparam [2:0] ST_DIRECT = 3'h2;
	localparam [2:0] ST_CMDRD  = 3'h4;

	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	wire sclkLvl;
	wire csLvl;
	wire dinLvl;

	pin_sync #(.RESET_VAL(1'b0)) syncSclk (
		.core_clk(core_clk),
		.resetn  (resetn),
		.clkEn   (clkEn),
		.pinIn   (sclk),
		.level   (sclkLvl)
	);

	pin_sync #(.RESET_VAL(1'b1)) syncCs (
		.core_clk(core_clk),
		.resetn  (resetn),
		.clkEn   (clkEn),
		.pinIn   (chipSelectN),
		.level   (csLvl)
	);

	pin_sync #(.RESET_VAL(1'b0)) syncDin (
		.core_clk(core_clk),
		.resetn  (resetn),
		.clkEn   (clkEn),
		.pinIn   (serialIn),
		.level   (dinLvl)
	);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	reg                 sclkPrev;
	reg [2:0]           state;
	reg [`BYTE_W-1:0]   rxShift;
	reg [2:0]           rxCount;
	reg [2:0]           txByte;
	reg [2:0]           txBit;
	reg [`MAIN_W-1:0]   txWord;
	reg [`BYTE_W-1:0]   txStatus;
	reg [`BYTE_W-1:0]   txChk;
	reg                 directArmed;
	reg [`MAIN_W-1:0]   mainHold;
	reg [`BYTE_W-1:0]   mainChkHold;
	reg [`AUX_W-1:0]    auxHold;
	reg [`BYTE_W-1:0]   auxChkHold;
	reg                 mainNew;
	reg                 auxNew;

	wire sclkRise = sclkLvl & ~sclkPrev & ~csLvl;
	wire sclkFall = ~sclkLvl & sclkPrev & ~csLvl;
	wire [`BYTE_W-1:0] rxByte = {rxShift[`BYTE_W-2:0], dinLvl};
	wire byteDone = sclkFall && (rxCount == `LAST_BIT) && (state != ST_CMDRD);

	wire opMain = (rxByte == `OP_READ_MAIN_A) || (rxByte == `OP_READ_MAIN_B);
	wire opAux  = (rxByte == `OP_READ_AUX_A) || (rxByte == `OP_READ_AUX_B);

	wire [2:0] seqLen = `WORD_BYTES + {2'h0, statusEnable} + {2'h0, checksumEnable};
	wire [2:0] lastIdx = seqLen - 3'h1;

	// busy whenever any transaction is underway
	wire busy = regAccessBusy || (rxCount != `RST_CNT3) || (state == ST_CMDRD) ||
		((state == ST_DIRECT) && (txBit != `RST_CNT3));

	wire [`ALARM_W-1:0] alarms = {low_reference_alarm, amp_low_alarm,
		amp_high_alarm, amp_differential_alarm};
	wire [`BYTE_W-1:0] mainStatus = {auxNew, 1'b1, clock_source_flag, alarms, resetFlag};
	wire [`BYTE_W-1:0] cmdMainStatus = {auxNew, mainNew, clock_source_flag, alarms,
		resetFlag};
	wire [`BYTE_W-1:0] auxStatus = {auxNew, mainNew, clock_source_flag,
		{`ALARM_W{1'b0}}, resetFlag};

	// ----------------------------------------------------------------
	// Byte sequence selection
	// ----------------------------------------------------------------
	// status, four word bytes, checksum; shift without status
	function [`BYTE_W-1:0] seqByte;
		input [2:0]         idx;
		input               stEn;
		input [`MAIN_W-1:0] word;
		input [`BYTE_W-1:0] stat;
		input [`BYTE_W-1:0] chk;
		reg   [2:0]         pos;
		begin
			pos = idx - {2'h0, stEn};
			if (stEn && (idx == `RST_CNT3)) begin
				seqByte = stat;
			end else if (pos == 3'h0) begin
				seqByte = word[31:24];
			end else if (pos == 3'h1) begin
				seqByte = word[23:16];
			end else if (pos == 3'h2) begin
				seqByte = word[15:8];
			end else if (pos == 3'h3) begin
				seqByte = word[7:0];
			end else begin
				seqByte = chk;
			end
		end
	endfunction

	wire [`BYTE_W-1:0] curByte = seqByte(txByte, statusEnable, txWord, txStatus, txChk);

	// ----------------------------------------------------------------
	// Ready output next value
	// ----------------------------------------------------------------
	reg next_readyN;

	always @* begin
		next_readyN = conversion_ready_n;
		if (pulseMode && convStart) begin
			next_readyN = 1'b1;
		end else if (!pulseMode && sclkFall) begin
			next_readyN = 1'b1;
		end
		if (mainReady) begin
			next_readyN = 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Main sequential logic
	// ----------------------------------------------------------------
	always @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			sclkPrev             <= 1'b0;
			state                <= ST_IDLE;
			rxShift              <= `RST_BYTE;
			rxCount              <= `RST_CNT3;
			txByte               <= `RST_CNT3;
			txBit                <= `RST_CNT3;
			txWord               <= `RST_WORD;
			txStatus             <= `RST_BYTE;
			txChk                <= `RST_BYTE;
			directArmed          <= 1'b0;
			mainHold             <= `RST_WORD;
			mainChkHold          <= `RST_BYTE;
			auxHold              <= `RST_AUX;
			auxChkHold           <= `RST_BYTE;
			mainNew              <= 1'b0;
			auxNew               <= 1'b0;
			resetFlag            <= 1'b1;
			conversion_ready_n   <= 1'b1;
			serial_out_ready_pin <= 1'b1;
			serialOutEn          <= 1'b0;
			cmdStrobe            <= 1'b0;
			cmdByte              <= `RST_BYTE;
		end else if (clkEn) begin
			sclkPrev           <= sclkLvl;
			cmdStrobe          <= 1'b0;
			conversion_ready_n <= next_readyN;
			serialOutEn        <= ~csLvl;
			resetFlag          <= resetFlag & ~resetFlagClear;

			// new-data flags, set wins over clear
			mainNew <= mainReady | (mainNew & ~convRestart &
				~(byteDone && opMain) & ~(sclkRise && (state == ST_IDLE) && directArmed));
			auxNew  <= auxReady | (auxNew & ~(byteDone && opAux));

			if (convRestart && !mainReady) begin
				mainHold    <= `RST_WORD;
				mainChkHold <= `RST_BYTE;
			end
			if (mainReady) begin
				mainHold    <= mainResult;
				mainChkHold <= mainChecksum;
			end
			if (auxReady) begin
				auxHold    <= auxResult;
				auxChkHold <= auxChecksum;
			end

			if (csLvl) begin
				state   <= ST_IDLE;
				rxCount <= `RST_CNT3;
				txByte  <= `RST_CNT3;
				txBit   <= `RST_CNT3;
			end else begin
				// full duplex receive; ignored during read
				if (sclkFall && (state != ST_CMDRD)) begin
					rxShift <= rxByte;
					rxCount <= rxCount + 3'h1;
				end
				if (byteDone) begin
					if (opMain || opAux) begin
						txByte <= `RST_CNT3;
						txBit  <= `RST_CNT3;
					end
					if (opMain) begin
						state    <= ST_CMDRD;
						txWord   <= mainHold;
						txStatus <= cmdMainStatus;
						txChk    <= mainChkHold;
					end else if (opAux) begin
						state    <= ST_CMDRD;
						txWord   <= {auxHold, `PAD_BYTE};
						txStatus <= auxStatus;
						txChk    <= auxChkHold;
					end else begin
						// other commands go to the executor
						cmdStrobe <= 1'b1;
						cmdByte   <= rxByte;
					end
				end else if ((state == ST_CMDRD) && sclkFall && (txByte == seqLen)) begin
					state <= ST_IDLE;
				end
				// first clock rise after ready starts direct stream
				if (sclkRise && (state == ST_IDLE) && directArmed) begin
					state       <= ST_DIRECT;
					directArmed <= 1'b0;
				end
				// each rise presents the next bit, MSB first
				if (sclkRise && ((state != ST_IDLE) || directArmed) &&
						!((state == ST_CMDRD) && (txByte == seqLen))) begin
					serial_out_ready_pin <= curByte[`LAST_BIT - txBit];
					txBit                <= txBit + 3'h1;
					if (txBit == `LAST_BIT) begin
						// direct stream wraps to first byte
						if ((txByte == lastIdx) && (state != ST_CMDRD)) begin
							txByte <= `RST_CNT3;
						end else begin
							txByte <= txByte + 3'h1;
						end
					end
				end
			end

			// load shift register only when nothing is underway
			// only the main result loads it here; aux command reads also load it
			if (mainReady && !busy) begin
				directArmed <= 1'b1;
				txWord      <= mainResult;
				txStatus    <= mainStatus;
				txChk       <= mainChecksum;
				txByte      <= `RST_CNT3;
				txBit       <= `RST_CNT3;
				if (state == ST_DIRECT) begin
					state <= ST_IDLE;
				end
			end

			// pin follows ready while no data are streaming
			if (((state == ST_IDLE) && !directArmed) || (mainReady && !busy)) begin
				serial_out_ready_pin <= next_readyN;
			end
		end
	end

endmodule

/* dv/readback_properties.sv */
// Port-level properties of the conversion data readback block
`timescale 1ns/1ps
module readback_properties (
	// Clock and reset
	input wire       core_clk,
	input wire       resetn,
	input wire       clkEn,
	// Watched ports
	input wire       chipSelectN,
	input wire       mainReady,
	input wire       pulseMode,
	input wire       convStart,
	input wire       resetFlagClear,
	input wire       serial_out_ready_pin,
	input wire       serialOutEn,
	input wire       conversion_ready_n,
	input wire       cmdStrobe,
	input wire [7:0] cmdByte,
	input wire       resetFlag
);
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!resetn);

	a_ready_on_data: assert property (mainReady |=> !conversion_ready_n)
		else $error("ready stayed high after a result");
	a_pin_with_ready: assert property ($fell(conversion_ready_n) && serialOutEn
		|-> !serial_out_ready_pin) else $error("shared pin missed ready");
	a_pulse_hold: assert property (pulseMode && !conversion_ready_n && !convStart
		|=> !conversion_ready_n) else $error("ready released early");
	a_pulse_release: assert property ($rose(conversion_ready_n) && pulseMode
		|-> $past(convStart)) else $error("ready rose without start");
	a_flag_hold: assert property (resetFlag && !resetFlagClear |=> resetFlag)
		else $error("reset flag dropped");
	a_flag_clear: assert property ($fell(resetFlag) |-> $past(resetFlagClear))
		else $error("reset flag fell uncleared");
	a_strobe_single: assert property (cmdStrobe |=> !cmdStrobe [*8])
		else $error("command strobe too soon");
	a_byte_strobe: assert property ($changed(cmdByte) |-> cmdStrobe)
		else $error("command byte changed alone");
	a_drive_selected: assert property ((!chipSelectN && clkEn) [*8] |-> serialOutEn)
		else $error("pin not driven");
	a_release_idle: assert property ((chipSelectN && clkEn) [*8] |-> !serialOutEn)
		else $error("pin driven unselected");

	c_command: cover property (cmdStrobe);
	c_pulse_release: cover property (pulseMode && $rose(conversion_ready_n));
	c_flag_clear: cover property ($fell(resetFlag));
endmodule

bind conversion_data_readback readback_properties i_props (
	.core_clk, .resetn, .clkEn, .chipSelectN, .mainReady, .pulseMode, .convStart,
	.resetFlagClear, .serial_out_ready_pin, .serialOutEn, .conversion_ready_n,
	.cmdStrobe, .cmdByte, .resetFlag
);

/* dv/serial_host.sv */
// Serial bus master model for the readback link
`timescale 1ns/1ps
module serial_host (
	// Link pins
	output reg       sclk,
	output reg       chipSelectN,
	output reg       serialIn,
	input  wire      dataLine,
	// Received byte report
	output reg [7:0] rxByte,
	output reg       rxStb
);
	integer i;

	initial begin
		sclk = 1'b0;
		chipSelectN = 1'b1;
		serialIn = 1'b0;
		rxByte = 8'h00;
		rxStb = 1'b0;
	end

	task select(input v);
		begin
			#3 chipSelectN = v;
			#200;
		end
	endtask

	// byte both ways, input low after
	task xfer(input [7:0] tx);
		begin
			for (i = 7; i >= 0; i = i - 1) begin
				serialIn = tx[i];
				sclk = 1'b1;
				#80 sclk = 1'b0;
				#70 rxByte[i] = dataLine;
				#10;
			end
			serialIn = 1'b0;
			rxStb = 1'b1;
			#1 rxStb = 1'b0;
		end
	endtask
endmodule

/* dv/tb_top.sv */
// Self-checking bench for the conversion data readback block
`timescale 1ns/1ps
`include "readback_consts.vh"
module tb_top;
	reg         core_clk = 1'b0;
	reg         resetn = 1'b0;
	reg         clkEn = 1'b1;
	reg  [4:0]  pls = 5'h00;
	reg  [31:0] mainResult = 32'h0;
	reg  [7:0]  mainChecksum = 8'h00;
	reg  [23:0] auxResult = 24'h0;
	reg  [7:0]  auxChecksum = 8'h00;
	reg         statusEnable = 1'b0;
	reg         checksumEnable = 1'b0;
	reg         pulseMode = 1'b0;
	reg         regAccessBusy = 1'b0;
	reg         clock_source_flag = 1'b0;
	reg  [3:0]  alarm = 4'h0;
	wire        sclk;
	wire        chipSelectN;
	wire        serialIn;
	wire        serial_out_ready_pin;
	wire        serialOutEn;
	wire        conversion_ready_n;
	wire        cmdStrobe;
	wire [7:0]  cmdByte;
	wire        resetFlag;
	wire [7:0]  rxByte;
	wire        rxStb;
	wire        dataLine;
	reg  [31:0] seed;
	reg  [39:0] mainHold;
	reg  [39:0] shiftHold;
	reg         mainNew = 1'b0;
	reg         auxNew = 1'b0;
	reg  [15:0] e;
	reg  [15:0] expQ[$];
	reg  [7:0]  cmdQ[$];
	integer     err_total = 0;
	integer     comparisons = 0;

	always #10 core_clk = ~core_clk;
	// Undriven shared pin shows the inverse of serial_out_ready_pin
	assign dataLine = serialOutEn ? serial_out_ready_pin : ~serial_out_ready_pin;

	conversion_data_readback i_dut (
		.core_clk, .resetn, .clkEn, .sclk, .chipSelectN, .serialIn,
		.serial_out_ready_pin, .serialOutEn, .mainReady(pls[0]), .mainResult,
		.mainChecksum, .auxReady(pls[1]), .auxResult, .auxChecksum, .statusEnable,
		.checksumEnable, .pulseMode, .convStart(pls[2]), .convRestart(pls[3]),
		.regAccessBusy, .clock_source_flag, .low_reference_alarm(alarm[3]),
		.amp_low_alarm(alarm[2]), .amp_high_alarm(alarm[1]),
		.amp_differential_alarm(alarm[0]), .resetFlagClear(pls[4]),
		.conversion_ready_n, .cmdStrobe, .cmdByte, .resetFlag
	);
	serial_host i_host (.sclk, .chipSelectN, .serialIn, .dataLine, .rxByte, .rxStb);

	task automatic check(input [7:0] got, input [7:0] exp);
		begin
			comparisons = comparisons + 1;
			if (got !== exp) begin
				err_total = err_total + 1;
				$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
			end
		end
	endtask

	task note(input [7:0] v, input [7:0] m);
		expQ.push_back({m, v});
	endtask

	task pulse(input [4:0] p);
		begin
			@(posedge core_clk) pls <= p;
			@(posedge core_clk) pls <= 5'h00;
			repeat (2) @(posedge core_clk);
		end
	endtask

	task cfg(input [2:0] m);
		reg [31:0] r;
		begin
			r = $random(seed);
			@(posedge core_clk);
			{statusEnable, checksumEnable, pulseMode, clock_source_flag, alarm} <= {m, r[4:0]};
		end
	endtask

	task newData(input aux, input busy);
		begin
			@(posedge core_clk);
			regAccessBusy <= busy;
			if (aux) {auxResult, auxChecksum} <= $random(seed);
			else {mainResult, mainChecksum} <= {$random(seed), $random(seed)};
			pulse(aux ? 5'h02 : 5'h01);
			regAccessBusy <= 1'b0;
			if (aux) auxNew = 1'b1;
			else begin
				mainHold = {mainResult, mainChecksum};
				mainNew = 1'b1;
				if (!busy) shiftHold = mainHold;
			end
		end
	endtask

	// Expected bytes in order, wrapping after the last one
	task stream(input [7:0] st, input [39:0] wc, input integer extra, input [7:0] tx);
		reg [7:0] s[0:5];
		integer n, k;
		begin
			n = 0;
			if (statusEnable) begin s[n] = st; n = n + 1; end
			for (k = 4; k >= 1; k = k - 1) begin s[n] = wc[8*k +: 8]; n = n + 1; end
			if (checksumEnable) begin s[n] = wc[7:0]; n = n + 1; end
			for (k = 0; k < n + extra; k = k + 1) begin
				note(s[k % n], 8'hff);
				i_host.xfer(k == 1 ? tx : 8'h00);
			end
		end
	endtask

	task directRead;
		begin
			cmdQ.push_back(8'h0a);
			#3;
			stream({auxNew, 1'b1, clock_source_flag, alarm, 1'b0}, shiftHold, 1, 8'h0a);
			mainNew = 1'b0;
		end
	endtask

	task readCmd(input [7:0] op);
		reg a;
		begin
			a = op[2];
			i_host.select(1'b1);
			i_host.select(1'b0);
			note(8'h00, 8'h00);
			i_host.xfer(op);
			stream({auxNew, mainNew, clock_source_flag, a ? 4'h0 : alarm, 1'b0},
				a ? {auxResult, `PAD_BYTE, auxChecksum} : mainHold, 0, 8'h0b);
			if (a) auxNew = 1'b0;
			else mainNew = 1'b0;
		end
	endtask

	task end_of_test;
		begin
			$display("comparisons %0d mismatches %0d", comparisons, err_total);
			if (err_total == 0 && comparisons > 0)
				$display("DONE - PASS");
			else
				$display("DONE - FAIL");
			$finish;
		end
	endtask

	always @(posedge rxStb) begin
		e = (expQ.size() > 0) ? expQ.pop_front() : 16'h0000;
		check(rxByte & e[15:8], e[7:0] & e[15:8]);
	end

	always @(negedge core_clk)
		if (cmdStrobe === 1'b1 && cmdByte !== 8'h00)
			check(cmdByte, (cmdQ.size() > 0) ? cmdQ.pop_front() : 8'h00);

	initial begin
		#800000;
		err_total = err_total + 1;
		end_of_test;
	end

	initial begin
		seed = 32'h60293e42;
		repeat (4) @(posedge core_clk);
		resetn <= 1'b1;
		repeat (8) @(posedge core_clk);
		#1 check(resetFlag, 8'h01);
		check(conversion_ready_n, 8'h01);
		@(posedge core_clk) clkEn <= 1'b0;
		pulse(5'h10);
		#1 check(resetFlag, 8'h01);
		@(posedge core_clk) clkEn <= 1'b1;
		pulse(5'h10);
		#1 check(resetFlag, 8'h00);
		$display("reset flag test done");
		cfg(3'b110);
		i_host.select(1'b0);
		newData(1'b0, 1'b0);
		#1 check(conversion_ready_n, 8'h00);
		check(serial_out_ready_pin, 8'h00);
		directRead;
		#1 check(conversion_ready_n, 8'h01);
		$display("direct readback test done");
		cfg(3'b000);
		newData(1'b0, 1'b0);
		newData(1'b0, 1'b1);
		directRead;
		cfg(3'b110);
		readCmd(8'h12);
		newData(1'b0, 1'b1);
		readCmd(8'h13);
		readCmd(8'h12);
		$display("holding register test done");
		newData(1'b1, 1'b0);
		readCmd(8'h14);
		readCmd(8'h15);
		$display("aux readback test done");
		pulse(5'h08);
		mainHold = 40'h0;
		mainNew = 1'b0;
		readCmd(8'h12);
		cfg(3'b111);
		newData(1'b0, 1'b1);
		readCmd(8'h13);
		#1 check(conversion_ready_n, 8'h00);
		pulse(5'h04);
		#1 check(conversion_ready_n, 8'h01);
		check(expQ.size() + cmdQ.size(), 8'h00);
		$display("restart and pulse mode test done");
		end_of_test;
	end
endmodule
